// *** rtl/rpb_pkg.sv ***
// Constants for the reference profile register bank
package rpb_pkg;
  localparam int IDX_W = 12;
  localparam logic [IDX_W-1:0] IDX_P0_PH_LO = 12'h629;
  localparam logic [IDX_W-1:0] IDX_P0_PH_HI = 12'h62A;
  localparam logic [IDX_W-1:0] IDX_P0_PH_FILL = 12'h62B;
  localparam logic [IDX_W-1:0] IDX_P0_PH_DRAIN = 12'h62C;
  localparam logic [IDX_W-1:0] IDX_P0_FQ_B0 = 12'h62D;
  localparam logic [IDX_W-1:0] IDX_P0_FQ_B1 = 12'h62E;
  localparam logic [IDX_W-1:0] IDX_P0_FQ_B2 = 12'h62F;
  localparam logic [IDX_W-1:0] IDX_P0_FQ_FILL = 12'h630;
  localparam logic [IDX_W-1:0] IDX_P0_FQ_DRAIN = 12'h631;
  localparam logic [IDX_W-1:0] IDX_P1_PRIO = 12'h632;
  localparam logic [IDX_W-1:0] IDX_P1_PER_B0 = 12'h633;
  localparam logic [IDX_W-1:0] IDX_P1_PER_B1 = 12'h634;
  localparam logic [IDX_W-1:0] IDX_P1_PER_B2 = 12'h635;
  localparam logic [IDX_W-1:0] IDX_P1_PER_B3 = 12'h636;
  localparam logic [IDX_W-1:0] IDX_P1_PER_B4 = 12'h637;
  localparam logic [IDX_W-1:0] IDX_P1_PAD0 = 12'h638;
  localparam logic [IDX_W-1:0] IDX_P1_PAD1 = 12'h639;
  localparam logic [IDX_W-1:0] IDX_P1_INNER_B0 = 12'h63A;
  localparam logic [IDX_W-1:0] IDX_P1_INNER_B1 = 12'h63B;
  localparam logic [IDX_W-1:0] IDX_P1_INNER_B2 = 12'h63C;
  localparam logic [IDX_W-1:0] IDX_P1_OUTER_B0 = 12'h63D;
  localparam logic [IDX_W-1:0] IDX_P1_OUTER_B1 = 12'h63E;
  localparam logic [IDX_W-1:0] IDX_P1_OUTER_B2 = 12'h63F;
  localparam logic [IDX_W-1:0] IDX_P1_VAL_LO = 12'h640;
  localparam logic [IDX_W-1:0] IDX_P1_VAL_HI = 12'h641;
  localparam logic [IDX_W-1:0] IDX_P1_REDET_LO = 12'h642;
  localparam logic [IDX_W-1:0] IDX_P1_REDET_HI = 12'h643;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_0 = 12'h644;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_1 = 12'h645;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_2 = 12'h646;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_3 = 12'h647;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_4 = 12'h648;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_5 = 12'h649;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_6 = 12'h64A;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_7 = 12'h64B;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_8 = 12'h64C;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_9 = 12'h64D;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_10 = 12'h64E;
  localparam logic [IDX_W-1:0] IDX_P1_COEF_11 = 12'h64F;
  localparam logic [IDX_W-1:0] IDX_P1_END = 12'h67F;
  localparam logic [IDX_W-1:0] IDX_STATUS = 12'h700;
  localparam int BANK_DEPTH = 39;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_PRIO = 8'hBF;
  localparam logic [7:0] MASK_NIBBLE = 8'h0F;
  localparam logic [7:0] MASK_COEF_5 = 8'h7F;
  localparam logic [7:0] MASK_COEF_8 = 8'h3F;
  localparam int SCALE_BIT = 7;
  localparam int STAT_PRIO_ERR = 0;
  localparam int STAT_P0_NS = 1;
  localparam int STAT_ACTIVE = 2;
  localparam logic [25:0] PS_PER_NS = 26'h00003E8;
endpackage

// *** rtl/rpb_ahb_port.sv ***
// AHB-Lite slave front end: address capture, write strobe, registered read data
`timescale 1ns/1ps
`default_nettype none
module rpb_ahb_port (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [7:0] rd_byte_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  output logic wr_en_o,
  output logic [rpb_pkg::IDX_W-1:0] idx_o,
  output logic [7:0] wr_byte_o
);
  logic ph_valid_reg;
  logic ph_write_reg;
  logic [rpb_pkg::IDX_W-1:0] ph_idx_reg;
  logic rd_done_reg;
  logic [31:0] hrdata_reg;
  logic take;
  logic rd_stage;

  // Only whole-word transfers inside the low window are decoded
  assign take = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'h2) &
                (haddr_i[31:14] == 18'h00000) & (haddr_i[1:0] == 2'h0);
  assign rd_stage = ph_valid_reg & ~ph_write_reg;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_idx_reg <= '0;
    end else if (hready_i) begin
      ph_valid_reg <= take;
      ph_write_reg <= hwrite_i;
      ph_idx_reg <= haddr_i[13:2];
    end
  end

  // One wait state on reads so hrdata comes straight from a flop
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rd_done_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
    end else begin
      rd_done_reg <= rd_stage & ~rd_done_reg;
      if (rd_stage & ~rd_done_reg) begin
        hrdata_reg <= {24'h000000, rd_byte_i};
      end
    end
  end

  assign hreadyout_o = ~(rd_stage & ~rd_done_reg);
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_reg;
  assign wr_en_o = ph_valid_reg & ph_write_reg & hready_i;
  assign idx_o = ph_idx_reg;
  assign wr_byte_o = hwdata_i[7:0];

  read_wait_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (rd_stage && !rd_done_reg) |-> !hreadyout_o ##1 hreadyout_o)
    else $error("read data phase did not take exactly one wait state");
  write_nowait_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ph_valid_reg && ph_write_reg) |-> hreadyout_o)
    else $error("write data phase stalled");
endmodule
`default_nettype wire

// *** rtl/rpb_bank.sv ***
// Reference profile register bank: profile 0 lock detectors and profile 1 set
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rpb_bank (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic p0_phase_scale_i,
  input wire logic p1_ref_active_i,
  output logic [15:0] p0_phase_thresh_o,
  output logic [25:0] p0_phase_thresh_ps_o,
  output logic [7:0] p0_phase_fill_o,
  output logic [7:0] p0_phase_drain_o,
  output logic [23:0] p0_freq_thresh_o,
  output logic [7:0] p0_freq_fill_o,
  output logic [7:0] p0_freq_drain_o,
  output logic p1_phase_scale_o,
  output logic [2:0] p1_promoted_prio_o,
  output logic [2:0] p1_select_prio_o,
  output logic [2:0] p1_effective_prio_o,
  output logic [39:0] p1_ref_period_o,
  output logic [19:0] p1_inner_tol_o,
  output logic [19:0] p1_outer_tol_o,
  output logic [15:0] p1_valid_timer_o,
  output logic [15:0] p1_redetect_timer_o,
  output logic [15:0] p1_alpha0_lin_o,
  output logic [5:0] p1_alpha1_exp_o,
  output logic [2:0] p1_alpha2_exp_o,
  output logic [3:0] p1_alpha3_exp_o,
  output logic [16:0] p1_beta0_lin_o,
  output logic [4:0] p1_beta1_exp_o,
  output logic [16:0] p1_gamma0_lin_o,
  output logic [4:0] p1_gamma1_exp_o,
  output logic [14:0] p1_delta0_lin_o,
  output logic [4:0] p1_delta1_exp_o,
  output logic p1_prio_error_o
);
  logic [7:0] bank_reg [0:rpb_pkg::BANK_DEPTH-1];
  logic [25:0] p0_ps_reg;
  logic [2:0] eff_prio_reg;
  logic wr_en;
  logic [rpb_pkg::IDX_W-1:0] idx;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic [7:0] status;
  // Bytes holding split fields; assigns read the array itself so they track writes
  logic [7:0] prio_byte;
  logic [7:0] inner_top;
  logic [7:0] outer_top;
  logic [7:0] coef_b2;
  logic [7:0] coef_b3;
  logic [7:0] coef_b5;
  logic [7:0] coef_b8;
  logic [7:0] coef_b10;
  logic [7:0] coef_b11;

  function automatic logic in_bank(input logic [rpb_pkg::IDX_W-1:0] i);
    in_bank = (i >= rpb_pkg::IDX_P0_PH_LO) && (i <= rpb_pkg::IDX_P1_COEF_11);
  endfunction

  function automatic logic [5:0] bpos(input logic [rpb_pkg::IDX_W-1:0] i);
    logic [rpb_pkg::IDX_W-1:0] d;
    d = i - rpb_pkg::IDX_P0_PH_LO;
    bpos = d[5:0];
  endfunction

  function automatic logic [7:0] bval(input logic [rpb_pkg::IDX_W-1:0] i);
    bval = bank_reg[bpos(i)];
  endfunction

  // Writable bits per byte; everything else stays zero
  function automatic logic [7:0] wmask(input logic [rpb_pkg::IDX_W-1:0] i);
    unique case (i)
      rpb_pkg::IDX_P1_PRIO: wmask = rpb_pkg::MASK_PRIO;
      rpb_pkg::IDX_P1_PAD0,
      rpb_pkg::IDX_P1_PAD1: wmask = rpb_pkg::MASK_NONE;
      rpb_pkg::IDX_P1_INNER_B2,
      rpb_pkg::IDX_P1_OUTER_B2: wmask = rpb_pkg::MASK_NIBBLE;
      rpb_pkg::IDX_P1_COEF_5: wmask = rpb_pkg::MASK_COEF_5;
      rpb_pkg::IDX_P1_COEF_8: wmask = rpb_pkg::MASK_COEF_8;
      default: wmask = rpb_pkg::MASK_FULL;
    endcase
  endfunction

  function automatic logic [25:0] to_ps(input logic [15:0] t, input logic ns);
    to_ps = ns ? 26'(26'(t) * rpb_pkg::PS_PER_NS) : 26'(t);
  endfunction

  rpb_ahb_port u_port (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hready_i(hready_i),
    .hwdata_i(hwdata_i),
    .rd_byte_i(rd_byte),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .hrdata_o(hrdata_o),
    .wr_en_o(wr_en),
    .idx_o(idx),
    .wr_byte_o(wr_byte)
  );

  // Byte store; pad bytes in a pad-only block are masked off on write
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int k = 0; k < rpb_pkg::BANK_DEPTH; k++) begin
        bank_reg[k] <= rpb_pkg::RESET_BYTE;
      end
    end else if (wr_en && in_bank(idx)) begin
      bank_reg[bpos(idx)] <= wr_byte & wmask(idx);
    end
  end

  // Profile 1 space past the coefficients reads zero, status sits beyond
  always_comb begin
    if (in_bank(idx)) begin
      rd_byte = bval(idx);
    end else if (idx == rpb_pkg::IDX_STATUS) begin
      rd_byte = status;
    end else begin
      rd_byte = 8'h00;
    end
  end

  assign status = {5'h00, p1_ref_active_i, p0_phase_scale_i, p1_prio_error_o};

  assign prio_byte = bank_reg[bpos(rpb_pkg::IDX_P1_PRIO)];
  assign inner_top = bank_reg[bpos(rpb_pkg::IDX_P1_INNER_B2)];
  assign outer_top = bank_reg[bpos(rpb_pkg::IDX_P1_OUTER_B2)];
  assign coef_b2 = bank_reg[bpos(rpb_pkg::IDX_P1_COEF_2)];
  assign coef_b3 = bank_reg[bpos(rpb_pkg::IDX_P1_COEF_3)];
  assign coef_b5 = bank_reg[bpos(rpb_pkg::IDX_P1_COEF_5)];
  assign coef_b8 = bank_reg[bpos(rpb_pkg::IDX_P1_COEF_8)];
  assign coef_b10 = bank_reg[bpos(rpb_pkg::IDX_P1_COEF_10)];
  assign coef_b11 = bank_reg[bpos(rpb_pkg::IDX_P1_COEF_11)];

  // Profile 0 lock detector tail
  assign p0_phase_thresh_o = {bank_reg[bpos(rpb_pkg::IDX_P0_PH_HI)],
                              bank_reg[bpos(rpb_pkg::IDX_P0_PH_LO)]};
  assign p0_phase_fill_o = bank_reg[bpos(rpb_pkg::IDX_P0_PH_FILL)];
  assign p0_phase_drain_o = bank_reg[bpos(rpb_pkg::IDX_P0_PH_DRAIN)];
  assign p0_freq_thresh_o = {bank_reg[bpos(rpb_pkg::IDX_P0_FQ_B2)],
                             bank_reg[bpos(rpb_pkg::IDX_P0_FQ_B1)],
                             bank_reg[bpos(rpb_pkg::IDX_P0_FQ_B0)]};
  assign p0_freq_fill_o = bank_reg[bpos(rpb_pkg::IDX_P0_FQ_FILL)];
  assign p0_freq_drain_o = bank_reg[bpos(rpb_pkg::IDX_P0_FQ_DRAIN)];

  // Scale lives in the profile 0 priority byte, outside this bank
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      p0_ps_reg <= 26'h0000000;
    end else begin
      p0_ps_reg <= to_ps(p0_phase_thresh_o, p0_phase_scale_i);
    end
  end
  assign p0_phase_thresh_ps_o = p0_ps_reg;

  // Profile 1 priorities
  assign p1_phase_scale_o = prio_byte[rpb_pkg::SCALE_BIT];
  assign p1_promoted_prio_o = prio_byte[5:3];
  assign p1_select_prio_o = prio_byte[2:0];

  // Flags a promoted level that software set above the selection level
  assign p1_prio_error_o = p1_promoted_prio_o > p1_select_prio_o;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      eff_prio_reg <= 3'h0;
    end else begin
      eff_prio_reg <= p1_ref_active_i ? p1_promoted_prio_o : p1_select_prio_o;
    end
  end
  assign p1_effective_prio_o = eff_prio_reg;

  assign p1_ref_period_o = {bank_reg[bpos(rpb_pkg::IDX_P1_PER_B4)],
                            bank_reg[bpos(rpb_pkg::IDX_P1_PER_B3)],
                            bank_reg[bpos(rpb_pkg::IDX_P1_PER_B2)],
                            bank_reg[bpos(rpb_pkg::IDX_P1_PER_B1)],
                            bank_reg[bpos(rpb_pkg::IDX_P1_PER_B0)]};
  assign p1_inner_tol_o = {inner_top[3:0],
                           bank_reg[bpos(rpb_pkg::IDX_P1_INNER_B1)],
                           bank_reg[bpos(rpb_pkg::IDX_P1_INNER_B0)]};
  assign p1_outer_tol_o = {outer_top[3:0],
                           bank_reg[bpos(rpb_pkg::IDX_P1_OUTER_B1)],
                           bank_reg[bpos(rpb_pkg::IDX_P1_OUTER_B0)]};
  assign p1_valid_timer_o = {bank_reg[bpos(rpb_pkg::IDX_P1_VAL_HI)],
                             bank_reg[bpos(rpb_pkg::IDX_P1_VAL_LO)]};
  assign p1_redetect_timer_o = {bank_reg[bpos(rpb_pkg::IDX_P1_REDET_HI)],
                                bank_reg[bpos(rpb_pkg::IDX_P1_REDET_LO)]};

  // Linear parts are unsigned fractions, exponents passed raw to the filter
  assign p1_alpha0_lin_o = {bank_reg[bpos(rpb_pkg::IDX_P1_COEF_1)],
                            bank_reg[bpos(rpb_pkg::IDX_P1_COEF_0)]};
  assign p1_alpha1_exp_o = coef_b2[5:0];
  assign p1_alpha2_exp_o = {coef_b3[0], coef_b2[7:6]};
  assign p1_alpha3_exp_o = coef_b11[7:4];
  assign p1_beta0_lin_o = {coef_b5[1:0],
                           bank_reg[bpos(rpb_pkg::IDX_P1_COEF_4)],
                           coef_b3[7:1]};
  assign p1_beta1_exp_o = coef_b5[6:2];
  assign p1_gamma0_lin_o = {coef_b8[0],
                            bank_reg[bpos(rpb_pkg::IDX_P1_COEF_7)],
                            bank_reg[bpos(rpb_pkg::IDX_P1_COEF_6)]};
  assign p1_gamma1_exp_o = coef_b8[5:1];
  assign p1_delta0_lin_o = {coef_b10[6:0],
                            bank_reg[bpos(rpb_pkg::IDX_P1_COEF_9)]};
  assign p1_delta1_exp_o = {coef_b11[3:0], coef_b10[7]};

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  pad_zero_a: assert property (
    bank_reg[bpos(rpb_pkg::IDX_P1_PAD0)] == 8'h00 &&
    bank_reg[bpos(rpb_pkg::IDX_P1_PAD1)] == 8'h00 && prio_byte[6] == 1'b0)
    else $error("unused bits hold a nonzero value");
  select_write_a: assert property (
    (wr_en && idx == rpb_pkg::IDX_P1_PRIO) |=> p1_select_prio_o == $past(wr_byte[2:0]))
    else $error("selection priority not taken from write");
  promoted_use_a: assert property (
    (p1_ref_active_i && $stable(p1_promoted_prio_o)) |=>
    p1_effective_prio_o == $past(p1_promoted_prio_o))
    else $error("active reference not using promoted priority");
  select_use_a: assert property (
    !p1_ref_active_i |=> p1_effective_prio_o == $past(p1_select_prio_o))
    else $error("inactive reference not using selection priority");
  ns_scale_a: assert property (
    p0_phase_scale_i |=> p0_phase_thresh_ps_o ==
    26'($past(p0_phase_thresh_o)) * rpb_pkg::PS_PER_NS)
    else $error("nanosecond threshold not scaled");
  tol_nibble_a: assert property (
    (wr_en && idx == rpb_pkg::IDX_P1_INNER_B2) |=>
    p1_inner_tol_o[19:16] == $past(wr_byte[3:0]) &&
    inner_top[7:4] == 4'h0)
    else $error("inner tolerance upper byte wrong");
  period_msb_a: assert property (
    (wr_en && idx == rpb_pkg::IDX_P1_PER_B4) |=> p1_ref_period_o[39:32] == $past(wr_byte))
    else $error("period top byte misplaced");
  freq_lsb_a: assert property (
    (wr_en && idx == rpb_pkg::IDX_P0_FQ_B0) |=> p0_freq_thresh_o[7:0] == $past(wr_byte))
    else $error("frequency threshold low byte misplaced");
  alpha2_split_a: assert property (
    (wr_en && idx == rpb_pkg::IDX_P1_COEF_3) |=> p1_alpha2_exp_o[2] == $past(wr_byte[0]))
    else $error("alpha-2 exponent top bit misplaced");
  outer_nibble_a: assert property (
    (wr_en && idx == rpb_pkg::IDX_P1_OUTER_B2) |=>
    p1_outer_tol_o[19:16] == $past(wr_byte[3:0]) && outer_top[7:4] == 4'h0)
    else $error("outer tolerance upper byte wrong");
  valid_hi_a: assert property (
    (wr_en && idx == rpb_pkg::IDX_P1_VAL_HI) |=> p1_valid_timer_o[15:8] == $past(wr_byte))
    else $error("validation timer high byte misplaced");
  redet_lo_a: assert property (
    (wr_en && idx == rpb_pkg::IDX_P1_REDET_LO) |=> p1_redetect_timer_o[7:0] == $past(wr_byte))
    else $error("redetect timer low byte misplaced");
  ps_scale_a: assert property (
    !p0_phase_scale_i |=> p0_phase_thresh_ps_o == 26'($past(p0_phase_thresh_o)))
    else $error("picosecond threshold altered");
  scale_bit_a: assert property (
    (wr_en && idx == rpb_pkg::IDX_P1_PRIO) |=> p1_phase_scale_o == $past(wr_byte[7]))
    else $error("scale bit not taken from write");

  write_c: cover property (wr_en && in_bank(idx));
  status_read_c: cover property (idx == rpb_pkg::IDX_STATUS && !hreadyout_o);
  promoted_c: cover property (p1_ref_active_i && p1_promoted_prio_o != p1_select_prio_o);
  ns_c: cover property (p0_phase_scale_i && p0_phase_thresh_o != 16'h0000);
endmodule
`default_nettype wire

// *** test/tb_reference_profile_register_bank.sv ***
// Self-checking bench for the reference profile register bank
`timescale 1ns/1ps
`default_nettype none
module tb_reference_profile_register_bank;
  logic sys_clk_i, reset_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
  logic p0_phase_scale_i, p1_ref_active_i, p1_phase_scale_o, p1_prio_error_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i, p1_promoted_prio_o, p1_select_prio_o, p1_effective_prio_o;
  logic [15:0] p0_phase_thresh_o, p1_valid_timer_o, p1_redetect_timer_o, p1_alpha0_lin_o;
  logic [25:0] p0_phase_thresh_ps_o;
  logic [7:0] p0_phase_fill_o, p0_phase_drain_o, p0_freq_fill_o, p0_freq_drain_o;
  logic [23:0] p0_freq_thresh_o;
  logic [39:0] p1_ref_period_o;
  logic [19:0] p1_inner_tol_o, p1_outer_tol_o;
  logic [5:0] p1_alpha1_exp_o;
  logic [2:0] p1_alpha2_exp_o;
  logic [3:0] p1_alpha3_exp_o;
  logic [16:0] p1_beta0_lin_o, p1_gamma0_lin_o;
  logic [14:0] p1_delta0_lin_o;
  logic [4:0] p1_beta1_exp_o, p1_gamma1_exp_o, p1_delta1_exp_o;
  int error_cnt = 0;
  int total_checks = 0;

  // Single slave, so its ready is the bus ready
  assign hready_i = hreadyout_o;

  rpb_bank u_rpb_bank (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
    .hwdata_i(hwdata_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .p0_phase_scale_i(p0_phase_scale_i), .p1_ref_active_i(p1_ref_active_i),
    .p0_phase_thresh_o(p0_phase_thresh_o), .p0_phase_thresh_ps_o(p0_phase_thresh_ps_o),
    .p0_phase_fill_o(p0_phase_fill_o), .p0_phase_drain_o(p0_phase_drain_o),
    .p0_freq_thresh_o(p0_freq_thresh_o), .p0_freq_fill_o(p0_freq_fill_o),
    .p0_freq_drain_o(p0_freq_drain_o), .p1_phase_scale_o(p1_phase_scale_o),
    .p1_promoted_prio_o(p1_promoted_prio_o), .p1_select_prio_o(p1_select_prio_o),
    .p1_effective_prio_o(p1_effective_prio_o), .p1_ref_period_o(p1_ref_period_o),
    .p1_inner_tol_o(p1_inner_tol_o), .p1_outer_tol_o(p1_outer_tol_o),
    .p1_valid_timer_o(p1_valid_timer_o), .p1_redetect_timer_o(p1_redetect_timer_o),
    .p1_alpha0_lin_o(p1_alpha0_lin_o), .p1_alpha1_exp_o(p1_alpha1_exp_o),
    .p1_alpha2_exp_o(p1_alpha2_exp_o), .p1_alpha3_exp_o(p1_alpha3_exp_o),
    .p1_beta0_lin_o(p1_beta0_lin_o), .p1_beta1_exp_o(p1_beta1_exp_o),
    .p1_gamma0_lin_o(p1_gamma0_lin_o), .p1_gamma1_exp_o(p1_gamma1_exp_o),
    .p1_delta0_lin_o(p1_delta0_lin_o), .p1_delta1_exp_o(p1_delta1_exp_o),
    .p1_prio_error_o(p1_prio_error_o)
  );

  initial sys_clk_i = 1'b0;
  always #50 sys_clk_i = ~sys_clk_i;

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_field(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected field at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for an edge with ready high; the bench watchdog bounds the wait
  task automatic wait_rdy;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
  endtask

  task automatic ahb_write(input logic [11:0] idx, input logic [7:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {18'h00000, idx, 2'b00};
    htrans_i <= 2'b10;
    hwrite_i <= 1'b1;
    hsize_i <= 3'b010;
    wait_rdy();
    htrans_i <= 2'b00;
    hwdata_i <= {24'h000000, d};
    wait_rdy();
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
    hsel_i <= 1'b1;
    haddr_i <= {18'h00000, idx, 2'b00};
    htrans_i <= 2'b10;
    hwrite_i <= 1'b0;
    hsize_i <= 3'b010;
    wait_rdy();
    htrans_i <= 2'b00;
    wait_rdy();
    check_word(hrdata_o, {24'h000000, exp});
    check_word({31'h00000000, hresp_o}, 32'h00000000);
  endtask

  // Outputs follow a write or an input change within two edges
  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 39; i++) rd_chk(rpb_pkg::IDX_P0_PH_LO + 12'(i), 8'h00);
    check_field(p1_ref_period_o, 40'h0000000000);
  endtask

  task automatic t_p0;
    for (int i = 0; i < 9; i++) ahb_write(rpb_pkg::IDX_P0_PH_LO + 12'(i), 8'(8'h11 * (i + 1)));
    settle();
    check_field(40'(p0_phase_thresh_o), 40'h0000002211);
    check_field(40'(p0_phase_thresh_ps_o), 40'h0000002211);
    check_field({p0_phase_fill_o, p0_phase_drain_o}, 40'h0000003344);
    check_field(40'(p0_freq_thresh_o), 40'h0000776655);
    check_field({p0_freq_fill_o, p0_freq_drain_o}, 40'h0000008899);
    @(posedge sys_clk_i);
    p0_phase_scale_i <= 1'b1;
    settle();
    check_field(40'(p0_phase_thresh_ps_o), 40'(26'h0002211 * rpb_pkg::PS_PER_NS));
    for (int i = 0; i < 9; i++) rd_chk(rpb_pkg::IDX_P0_PH_LO + 12'(i), 8'(8'h11 * (i + 1)));
  endtask

  task automatic t_prio;
    ahb_write(rpb_pkg::IDX_P1_PRIO, 8'hFF);
    rd_chk(rpb_pkg::IDX_P1_PRIO, 8'hBF);
    settle();
    check_field(40'(p1_phase_scale_o), 40'h0000000001);
    for (int v = 0; v < 8; v++) begin
      ahb_write(rpb_pkg::IDX_P1_PRIO, {2'b00, 3'(7 - v), 3'(v)});
      p1_ref_active_i <= 1'b0;
      settle();
      check_field({p1_promoted_prio_o, p1_select_prio_o}, 40'({3'(7 - v), 3'(v)}));
      check_field(40'(p1_effective_prio_o), 40'(v));
      check_field(40'(p1_prio_error_o), 40'(7 - v > v));
      @(posedge sys_clk_i);
      p1_ref_active_i <= 1'b1;
      settle();
      check_field(40'(p1_effective_prio_o), 40'(7 - v));
    end
  endtask

  task automatic t_period;
    logic [7:0] v;
    for (int i = 0; i < 17; i++) begin
      v = (i == 5 || i == 6) ? 8'h00 : 8'(8'h90 + i);
      ahb_write(rpb_pkg::IDX_P1_PER_B0 + 12'(i), v);
    end
    settle();
    check_field(p1_ref_period_o, 40'h9493929190);
    check_field(40'(p1_inner_tol_o), 40'h0000099897);
    check_field(40'(p1_outer_tol_o), 40'h00000C9B9A);
    check_field(40'(p1_valid_timer_o), 40'h0000009E9D);
    check_field(40'(p1_redetect_timer_o), 40'h000000A09F);
    for (int i = 0; i < 17; i++) begin
      v = 8'(8'h90 + i);
      if (i == 5 || i == 6) v = 8'h00;
      if (i == 9 || i == 12) v = v & 8'h0F;
      rd_chk(rpb_pkg::IDX_P1_PER_B0 + 12'(i), v);
    end
  endtask

  task automatic t_coef;
    logic [7:0] c [12];
    for (int i = 0; i < 12; i++) c[i] = 8'(8'h91 + i * 8'h37);
    for (int i = 0; i < 12; i++) ahb_write(rpb_pkg::IDX_P1_COEF_0 + 12'(i), c[i]);
    settle();
    check_field(40'(p1_alpha0_lin_o), 40'({c[1], c[0]}));
    check_field(40'(p1_alpha1_exp_o), 40'(c[2][5:0]));
    check_field(40'(p1_alpha2_exp_o), 40'({c[3][0], c[2][7:6]}));
    check_field(40'(p1_alpha3_exp_o), 40'(c[11][7:4]));
    check_field(40'(p1_beta0_lin_o), 40'({c[5][1:0], c[4], c[3][7:1]}));
    check_field(40'(p1_beta1_exp_o), 40'(c[5][6:2]));
    check_field(40'(p1_gamma0_lin_o), 40'({c[8][0], c[7], c[6]}));
    check_field(40'(p1_gamma1_exp_o), 40'(c[8][5:1]));
    check_field(40'(p1_delta0_lin_o), 40'({c[10][6:0], c[9]}));
    check_field(40'(p1_delta1_exp_o), 40'({c[11][3:0], c[10][7]}));
    rd_chk(rpb_pkg::IDX_P1_COEF_5, c[5] & 8'h7F);
    rd_chk(rpb_pkg::IDX_P1_COEF_8, c[8] & 8'h3F);
    rd_chk(rpb_pkg::IDX_P1_COEF_11, c[11]);
  endtask

  task automatic t_edges;
    ahb_write(12'h650, 8'h5A);
    ahb_write(rpb_pkg::IDX_P1_END, 8'h5A);
    rd_chk(12'h650, 8'h00);
    rd_chk(rpb_pkg::IDX_P1_END, 8'h00);
    ahb_write(rpb_pkg::IDX_P1_PRIO, 8'h38);
    rd_chk(rpb_pkg::IDX_STATUS, 8'h07);
    // Reset in mid-run must clear everything written so far
    reset_i <= 1'b1;
    @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rd_chk(rpb_pkg::IDX_P1_PRIO, 8'h00);
    check_field(40'(p1_inner_tol_o), 40'h0000000000);
  endtask

  initial begin
    reset_i = 1'b1;
    hsel_i = 1'b0;
    haddr_i = 32'h00000000;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    hsize_i = 3'b010;
    hwdata_i = 32'h00000000;
    p0_phase_scale_i = 1'b0;
    p1_ref_active_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    t_reset();
    t_p0();
    t_prio();
    t_period();
    t_coef();
    t_edges();
    end_of_test();
  end

  // Whole run needs under 500 cycles; this limit leaves ample margin
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
